// ---- rtl/csc_pkg.sv ----
`default_nettype none
// ============================================================
// Cyclic sleep controller shared definitions
package csc_pkg;

   // Clock and timing constants
   localparam int CSC_CLK_PERIOD_NS = 8;          // System clock period
   localparam int CSC_TICK_MS       = 10;         // Sleep time base
   localparam int CSC_TICK_CYC      = CSC_TICK_MS * 1000000 / CSC_CLK_PERIOD_NS;
   localparam int CSC_POLL_MS       = 100;        // Awake poll interval
   localparam int CSC_POLL_TICKS    = CSC_POLL_MS / CSC_TICK_MS;
   localparam int CSC_ACK_WAIT_MS   = 20;         // Poll acknowledge timeout
   localparam int CSC_ACK_TICKS     = CSC_ACK_WAIT_MS / CSC_TICK_MS;
   localparam int CSC_MISS_LIMIT    = 3;          // Missed acks before parent loss

   // Mode select codes
   localparam logic [2:0] CSC_MODE_CYCLIC = 3'h4;  // Timer wake only
   localparam logic [2:0] CSC_MODE_PIN    = 3'h5;  // Timer or pin wake

   // Sleep period and multiplier limits
   localparam logic [11:0] CSC_SP_MIN = 12'h0020;
   localparam logic [11:0] CSC_SP_MAX = 12'h0AF0;
   localparam logic [15:0] CSC_SN_MIN = 16'h0001;

   // Sleep option bit positions
   localparam int CSC_OPT_FULL_HOLD = 1;          // Value 0x02
   localparam int CSC_OPT_EXTENDED  = 2;          // Value 0x04

   // Sequencer phases
   typedef enum logic [1:0] {
      CSC_OFF,
      CSC_SLEEP,
      CSC_POLL,
      CSC_AWAKE
   } csc_phase_t;

   // Configuration from the host side
   typedef struct packed {
      logic [2:0]  sleep_mode_select;       // Sleep mode code
      logic [11:0] sleep_period;            // Base period in ticks
      logic [15:0] period_multiplier;       // Number of periods
      logic [7:0]  sleep_options;           // Option bits
      logic [15:0] wake_hold_timer;         // Hold time in ticks
      logic        flow_control_pin_config; // Hardware flow control on
   } csc_cfg_t;

   // Whole sequencer state
   typedef struct packed {
      csc_phase_t  st;        // Current phase
      logic [20:0] tick_cnt;  // Tick prescaler
      logic [27:0] sleep_cnt; // Remaining sleep ticks
      logic [15:0] hold_cnt;  // Remaining hold ticks
      logic [3:0]  poll_cnt;  // Ticks since last poll
      logic [3:0]  ack_cnt;   // Ticks waiting for ack
      logic [1:0]  miss_cnt;  // Consecutive missed acks
      logic [15:0] wake_cnt;  // Silent wake cycles
      logic [2:0]  pin_sync;  // Pin synchroniser
      logic        pin_lvl;   // Filtered pin level
      logic        awake;     // Awake indicator
      logic        cts_n;     // Flow control, low means ready
      logic        poll_req;  // Poll request pulse
      logic        wake_tx;   // Wake announcement pulse
      logic        lost;      // Parent lost pulse
   } csc_state_t;

   // Reset value of the state
   localparam csc_state_t CSC_STATE_RST = '{st: CSC_OFF, cts_n: 1'b1, pin_lvl: 1'b1, pin_sync: 3'h7,
                                            default: '0};

endpackage : csc_pkg

`default_nettype wire

// ---- rtl/csc_cyclic_sleep_controller.sv ----
// Operation
// RULE_01: Cyclic sleep when mode is 4 or 5
// RULE_02: Mode 5 wakes on timer or pin fall
// RULE_03: Mode 4 ignores the request pin
// RULE_04: One poll per wake, stay if data
// RULE_05: Indicator high awake, low asleep
// RULE_06: CTS low awake, high asleep if enabled
// RULE_07: Hold timer starts and restarts on data
// RULE_08: Poll parent every 100 ms while awake
// RULE_09: Sleep on hold expiry or sleep command
// RULE_10: Sleep period 0x20 to 0xAF0 ticks
// RULE_11: Multiplier 1 to 0xFFFF
// RULE_12: Option bits full hold and extended
// RULE_13: Short sleep lasts one period then polls
// RULE_14: Pending data starts hold, keeps polling
// RULE_15: Multiplier one raises indicator every wake
// RULE_16: Multiplier above one polls silently
// RULE_17: Extended sleep is period times multiplier
// RULE_18: Extended wake sends an announcement
// RULE_19: Configurer should set full hold option
// RULE_20: Three missed acks means parent lost
// RULE_21: Wake counter gates the indicator
`timescale 1ns/1ps
`default_nettype none

module csc_cyclic_sleep_controller #(
   parameter int TICK_CYCLES = csc_pkg::CSC_TICK_CYC
) (
   // Clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              sys_rst_i,
   // Configuration
   input  wire csc_pkg::csc_cfg_t cfg_i,
   // Host pins
   input  wire logic              sleep_request_pin_i,
   input  wire logic              serial_rx_i,
   input  wire logic              sleep_now_command_i,
   output logic                   awake_indicator_o,
   output logic                   cts_n_o,
   // Radio side
   input  wire logic              radio_rx_i,
   input  wire logic              poll_ack_i,
   input  wire logic              poll_pending_i,
   output logic                   poll_req_o,
   output logic                   wake_tx_req_o,
   output logic                   parent_lost_o
);
   import csc_pkg::*;

   // ============================================================
   // Derived configuration
   csc_state_t  r_reg;      // Registered state
   csc_state_t  r_next;     // Next state
   logic        tick;       // 10 ms time base pulse
   logic        cyclic;     // Cyclic sleep selected
   logic        ext_mode;   // Extended sleep selected
   logic        full_hold;  // Always wake for full hold time
   logic        pin_fall;   // Filtered falling edge on request pin
   logic [11:0] sp_eff;     // Clamped sleep period
   logic [15:0] sn_eff;     // Clamped multiplier
   logic [27:0] sleep_len;  // Sleep length in ticks

   // Limit the period and multiplier to the accepted ranges
   always_comb begin : cfg_proc
      // RULE_10 period range clamp
      if (cfg_i.sleep_period < CSC_SP_MIN) begin
         sp_eff = CSC_SP_MIN;
      end else if (cfg_i.sleep_period > CSC_SP_MAX) begin
         sp_eff = CSC_SP_MAX;
      end else begin
         sp_eff = cfg_i.sleep_period;
      end
      // RULE_11 multiplier floor of one
      sn_eff    = (cfg_i.period_multiplier < CSC_SN_MIN) ? CSC_SN_MIN : cfg_i.period_multiplier;
      // RULE_01 cyclic mode decode
      cyclic    = (cfg_i.sleep_mode_select == CSC_MODE_CYCLIC) || (cfg_i.sleep_mode_select == CSC_MODE_PIN);
      // RULE_12 option bit decode
      full_hold = cfg_i.sleep_options[CSC_OPT_FULL_HOLD];
      ext_mode  = cfg_i.sleep_options[CSC_OPT_EXTENDED];
      // RULE_17 extended length is the product
      sleep_len = ext_mode ? (28'(sp_eff) * 28'(sn_eff)) : 28'(sp_eff);
   end

   // Time base and synchronised pin edge
   assign tick     = (r_reg.tick_cnt == 21'(TICK_CYCLES - 1));
   assign pin_fall = r_reg.pin_lvl & ~r_reg.pin_sync[1] & ~r_reg.pin_sync[2];

   // ============================================================
   // Sequencer next state
   always_comb begin : next_proc
      logic go_sleep;  // Enter sleep this cycle
      logic ack_done;  // Poll answered or timed out
      go_sleep        = 1'b0;
      ack_done        = 1'b0;
      r_next          = r_reg;
      r_next.poll_req = 1'b0;
      r_next.wake_tx  = 1'b0;
      r_next.lost     = 1'b0;
      // Pin passes three flops, level taken when the last two agree
      r_next.pin_sync = {r_reg.pin_sync[1:0], sleep_request_pin_i};
      if (r_reg.pin_sync[2] == r_reg.pin_sync[1]) begin
         r_next.pin_lvl = r_reg.pin_sync[2];
      end
      // Free running prescaler
      r_next.tick_cnt = tick ? 21'h0_0000 : r_reg.tick_cnt + 21'h0_0001;

      if (!cyclic) begin
         // Not in cyclic sleep, park awake-off
         r_next.st       = CSC_OFF;
         r_next.awake    = 1'b0;
         r_next.hold_cnt = 16'h0000;
         r_next.wake_cnt = 16'h0000;
      end else begin
         unique case (r_reg.st)
            // Entry into cyclic sleep
            CSC_OFF: begin
               go_sleep = 1'b1;
            end
            // Low power, count the period down
            CSC_SLEEP: begin
               // RULE_02 timer or pin wake
               // RULE_03 pin only in pin wake mode
               if ((tick && r_reg.sleep_cnt == 28'h000_0000) ||
                   (pin_fall && cfg_i.sleep_mode_select == CSC_MODE_PIN)) begin
                  // RULE_04 one poll on every wake
                  r_next.st       = CSC_POLL;
                  r_next.poll_req = 1'b1;
                  r_next.ack_cnt  = 4'h0;
                  r_next.poll_cnt = 4'h0;
                  // RULE_12 full hold starts the timer at wake
                  r_next.hold_cnt = full_hold ? cfg_i.wake_hold_timer : 16'h0000;
                  if (ext_mode) begin
                     // RULE_18 announce the wake to peers
                     r_next.wake_tx  = 1'b1;
                     r_next.awake    = 1'b1;
                     r_next.wake_cnt = 16'h0000;
                  end else if (r_reg.wake_cnt >= sn_eff - 16'h0001) begin
                     // RULE_15 raise on every wake when one
                     // RULE_21 counter cleared on raise
                     r_next.awake    = 1'b1;
                     r_next.wake_cnt = 16'h0000;
                  end else begin
                     // RULE_16 silent poll, indicator stays low
                     r_next.wake_cnt = r_reg.wake_cnt + 16'h0001;
                  end
               end else if (tick) begin
                  // RULE_13 count one period down
                  r_next.sleep_cnt = r_reg.sleep_cnt - 28'h000_0001;
               end
            end
            // Poll sent, wait for the acknowledge
            CSC_POLL: begin
               if (poll_ack_i) begin
                  ack_done        = 1'b1;
                  r_next.miss_cnt = 2'h0;
                  if (poll_pending_i) begin
                     // RULE_14 pending data starts the hold timer
                     r_next.hold_cnt = cfg_i.wake_hold_timer;
                  end
               end else if (tick) begin
                  if (r_reg.ack_cnt == 4'(CSC_ACK_TICKS - 1)) begin
                     ack_done = 1'b1;
                     // RULE_20 three misses, parent lost
                     if (r_reg.miss_cnt == 2'(CSC_MISS_LIMIT - 1)) begin
                        r_next.lost     = 1'b1;
                        r_next.miss_cnt = 2'h0;
                     end else begin
                        r_next.miss_cnt = r_reg.miss_cnt + 2'h1;
                     end
                  end else begin
                     r_next.ack_cnt = r_reg.ack_cnt + 4'h1;
                  end
               end
               if (ack_done) begin
                  // RULE_04 stay awake only with a running hold timer
                  if ((poll_ack_i && poll_pending_i) || r_reg.hold_cnt != 16'h0000) begin
                     r_next.st = CSC_AWAKE;
                  end else begin
                     go_sleep = 1'b1;
                  end
               end
            end
            // Awake with hold timer running
            CSC_AWAKE: begin
               // RULE_09 hold expiry ends the wake
               if (r_reg.hold_cnt == 16'h0000) begin
                  go_sleep = 1'b1;
               end else if (tick) begin
                  // RULE_08 periodic poll every 100 ms
                  if (r_reg.poll_cnt == 4'(CSC_POLL_TICKS - 1)) begin
                     r_next.st       = CSC_POLL;
                     r_next.poll_req = 1'b1;
                     r_next.ack_cnt  = 4'h0;
                     r_next.poll_cnt = 4'h0;
                  end else begin
                     r_next.poll_cnt = r_reg.poll_cnt + 4'h1;
                  end
               end
            end
         endcase

         // Hold timer counts down while awake
         if ((r_reg.st == CSC_POLL || r_reg.st == CSC_AWAKE) && tick && r_reg.hold_cnt != 16'h0000) begin
            r_next.hold_cnt = r_reg.hold_cnt - 16'h0001;
         end
         // Data received while awake
         if (r_reg.st == CSC_POLL || r_reg.st == CSC_AWAKE) begin
            // RULE_07 start or restart the hold timer
            if ((serial_rx_i || radio_rx_i) && !go_sleep) begin
               r_next.hold_cnt = cfg_i.wake_hold_timer;
            end
            // RULE_16 radio data raises the indicator at once
            if (radio_rx_i && !go_sleep) begin
               r_next.awake    = 1'b1;
               r_next.wake_cnt = 16'h0000;
            end
            // RULE_09 sleep command ends the wake
            if (sleep_now_command_i) begin
               go_sleep = 1'b1;
            end
         end
      end

      // Common entry into sleep
      if (go_sleep) begin
         // RULE_05 indicator low on sleep
         r_next.st        = CSC_SLEEP;
         r_next.awake     = 1'b0;
         r_next.hold_cnt  = 16'h0000;
         r_next.sleep_cnt = sleep_len - 28'h000_0001;
      end
      // RULE_06 CTS follows the awake phases
      r_next.cts_n = cfg_i.flow_control_pin_config &&
                     !(r_next.st == CSC_POLL || r_next.st == CSC_AWAKE);
   end

   // State register
   always_ff @(posedge sys_clk_i) begin : state_proc
      if (sys_rst_i) begin
         r_reg <= CSC_STATE_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // Outputs straight from the state register
   assign awake_indicator_o = r_reg.awake;
   assign cts_n_o           = r_reg.cts_n;
   assign poll_req_o        = r_reg.poll_req;
   assign wake_tx_req_o     = r_reg.wake_tx;
   assign parent_lost_o     = r_reg.lost;

   // ============================================================
   // Checks
   logic awake_ph;  // In a polling or awake phase
   assign awake_ph = (r_reg.st == CSC_POLL) || (r_reg.st == CSC_AWAKE);

   cyclic_entry_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_01
      (r_reg.st == CSC_OFF && cyclic) |=> (r_reg.st == CSC_SLEEP || !$past(cyclic, 1)))
      else $error("cyclic mode not entered");
   pin_wake_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_02
      (r_reg.st == CSC_SLEEP && pin_fall && cfg_i.sleep_mode_select == CSC_MODE_PIN) |=> r_reg.st == CSC_POLL)
      else $error("pin wake missed");
   pin_ignored_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_03
      (r_reg.st == CSC_SLEEP && cfg_i.sleep_mode_select == CSC_MODE_CYCLIC && r_reg.sleep_cnt != 28'h000_0000)
      |=> r_reg.st == CSC_SLEEP)
      else $error("woke early in mode four");
   wake_poll_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_04
      (r_reg.st == CSC_SLEEP ##1 r_reg.st == CSC_POLL) |-> poll_req_o ##1 !poll_req_o)
      else $error("wake without single poll");
   sleep_ind_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_05
      r_reg.st == CSC_SLEEP |-> !awake_indicator_o)
      else $error("indicator high in sleep");
   cts_level_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_06
      (cfg_i.flow_control_pin_config && $stable(cfg_i.flow_control_pin_config)) |-> (cts_n_o == !awake_ph))
      else $error("cts does not follow wake");
   hold_restart_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_07
      (awake_ph && serial_rx_i && !sleep_now_command_i && r_reg.hold_cnt != 16'h0000 && cyclic)
      |=> r_reg.hold_cnt == $past(cfg_i.wake_hold_timer))
      else $error("hold timer not restarted");
   poll_period_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_08
      (r_reg.st == CSC_AWAKE && tick && r_reg.hold_cnt != 16'h0000 && r_reg.poll_cnt == 4'(CSC_POLL_TICKS - 1)
       && !sleep_now_command_i && cyclic) |=> poll_req_o)
      else $error("periodic poll missing");
   sleep_cmd_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_09
      (awake_ph && sleep_now_command_i && cyclic) |=> (r_reg.st == CSC_SLEEP && !awake_indicator_o))
      else $error("sleep command ignored");
   radio_ind_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_16
      (awake_ph && radio_rx_i && !sleep_now_command_i && cyclic && r_reg.hold_cnt != 16'h0000) |=> awake_indicator_o)
      else $error("radio data did not raise indicator");
   ext_announce_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_18
      wake_tx_req_o |-> (poll_req_o && awake_indicator_o && ext_mode))
      else $error("wake announcement out of place");
   parent_lost_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_20
      parent_lost_o |-> ($past(r_reg.miss_cnt) == 2'h2 && r_reg.miss_cnt == 2'h0))
      else $error("parent lost too early");

   pin_wake_c : cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      r_reg.st == CSC_SLEEP && pin_fall ##1 r_reg.st == CSC_POLL);
   hold_wake_c : cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      r_reg.st == CSC_POLL ##1 r_reg.st == CSC_AWAKE);
   lost_c : cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) parent_lost_o);
   silent_c : cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      poll_req_o && !awake_indicator_o);

endmodule : csc_cyclic_sleep_controller

`default_nettype wire

// ---- bench/csc_parent_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Parent router model: answers each poll after a set delay while not muted
module csc_parent_model (
   // Clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       sys_rst_i,
   // Behaviour controls
   input  wire logic       mute_i,         // Never answer a poll
   input  wire logic       pend_i,         // Data buffered for the child
   input  wire logic [3:0] delay_i,        // Cycles from poll to ack, at least 1
   // Device side
   input  wire logic       poll_req_i,
   output logic            poll_ack_o,
   output logic            poll_pending_o
);
   logic [3:0] wait_reg = 4'h0;            // Countdown to the ack, 0 when idle
   logic       flip_reg = 1'b0;            // Filler that changes every cycle

   // Pending only means something with the ack, so it wanders elsewhere
   assign poll_pending_o = poll_ack_o ? pend_i : flip_reg;

   // Ack timing, one pulse per answered poll
   always_ff @(posedge sys_clk_i) begin
      flip_reg   <= ~flip_reg;
      poll_ack_o <= 1'b0;
      if (sys_rst_i) begin
         wait_reg <= 4'h0;
      end else if (poll_req_i && !mute_i) begin
         wait_reg <= delay_i;
      end else if (wait_reg == 4'h1) begin
         wait_reg   <= 4'h0;
         poll_ack_o <= 1'b1;
      end else if (wait_reg != 4'h0) begin
         wait_reg <= wait_reg - 4'h1;
      end
   end
endmodule : csc_parent_model
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench for the cyclic sleep controller
module tb;
   import csc_pkg::*;
   localparam int T = 4;                   // Clocks per tick in simulation
   // Design inputs
   logic        sys_clk = 1'b0;
   logic        sys_rst = 1'b1;
   csc_cfg_t    cfg     = '0;
   logic        pin     = 1'b1;
   logic        serial  = 1'b0;
   logic        cmd     = 1'b0;
   logic        radio   = 1'b0;
   // Parent model controls
   logic        mute    = 1'b0;
   logic        pend    = 1'b0;
   logic [3:0]  dly     = 4'h1;
   // Design outputs and parent answers
   logic        awake, cts_n, poll_req, wake_tx, lost, ack, ack_pend;
   // Bookkeeping
   int          error_cnt   = 0;
   int          comparisons = 0;
   int          seed        = 32'h08fc;
   int          n, c, len, i;
   logic [11:0] sp;

   // Clock
   initial forever #4 sys_clk = ~sys_clk;

   // ============================================================
   // Instances
   csc_cyclic_sleep_controller #(.TICK_CYCLES(T)) dut_u (
      .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .cfg_i(cfg), .sleep_request_pin_i(pin),
      .serial_rx_i(serial), .sleep_now_command_i(cmd), .awake_indicator_o(awake), .cts_n_o(cts_n),
      .radio_rx_i(radio), .poll_ack_i(ack), .poll_pending_i(ack_pend), .poll_req_o(poll_req),
      .wake_tx_req_o(wake_tx), .parent_lost_o(lost));
   csc_parent_model parent_u (
      .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .mute_i(mute), .pend_i(pend), .delay_i(dly),
      .poll_req_i(poll_req), .poll_ack_o(ack), .poll_pending_o(ack_pend));

   // ============================================================
   // Helpers
   // Expected sleep length in ticks, with clamping
   function automatic int exp_len(input logic [11:0] p, input logic [15:0] sn, input logic [7:0] so);
      int s;
      s = (p < CSC_SP_MIN) ? int'(CSC_SP_MIN) : (p > CSC_SP_MAX) ? int'(CSC_SP_MAX) : int'(p);
      return so[CSC_OPT_EXTENDED] ? s * ((sn == 16'h0000) ? 1 : int'(sn)) : s;
   endfunction : exp_len

   task automatic end_of_test();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   task automatic chk_bit(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask : chk_bit

   task automatic chk_rng(input int got, input int lo, input int hi, input string what);
      comparisons++;
      if (got < lo || got > hi) begin
         error_cnt++;
         $display("mismatch at %0t: %s count %0d", $time, what, got);
      end
   endtask : chk_rng

   // Bounded wait: 0 poll, 1 indicator low, 2 parent lost, 3 run out the bound
   task automatic wait_for(input int sel, input int limit);
      logic hit;
      n   = 0;
      c   = 0;
      hit = 1'b0;
      while (!hit && n <= limit) begin
         @(posedge sys_clk);
         #1 n++;
         if (poll_req === 1'b1) c++;
         hit = (sel == 0) ? (poll_req === 1'b1) : (sel == 1) ? (awake !== 1'b1) : (sel == 2) && (lost === 1'b1);
      end
      if (!hit && sel != 3) begin
         error_cnt++;
         $display("mismatch at %0t: wait %0d ran out", $time, sel);
         end_of_test();
      end
   endtask : wait_for

   // Load a configuration and reset around it
   task automatic do_reset(input logic [2:0] m, input logic [11:0] p, input logic [15:0] sn,
                           input logic [7:0] so, input logic [15:0] h, input logic fc);
      @(posedge sys_clk);
      cfg     <= '{m, p, sn, so, h, fc};
      sys_rst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      #1 chk_bit(awake, 1'b0, "indicator in reset");
      chk_bit(cts_n, 1'b1, "cts in reset");
      @(posedge sys_clk) sys_rst <= 1'b0;
   endtask : do_reset

   // ============================================================
   // Main sequence
   initial begin
      // short sleep with random period and ack delay
      for (i = 0; i < 2; i++) begin
         sp  = 12'h020 + 12'({$random(seed)} % 8);
         dly <= 4'(1 + {$random(seed)} % 3);
         do_reset(3'h4, sp, 16'h0001, 8'h00, 16'h0014, 1'b1);
         len = exp_len(sp, 16'h0001, 8'h00);
         wait_for(0, len * T + 2 * T);
         chk_rng(n, len * T - T, len * T + T + 4, "short sleep");
         chk_bit(awake, 1'b1, "indicator on wake");
         chk_bit(cts_n, 1'b0, "cts on wake");
         chk_bit(wake_tx, 1'b0, "no announcement");
         wait_for(3, 5);
         chk_bit(awake, 1'b0, "indicator after idle poll");
         chk_bit(cts_n, 1'b1, "cts after idle poll");
         wait_for(0, len * T + 2 * T);
         chk_rng(n, len * T - T - 2, len * T + T + 4, "second sleep");
      end
      $display("test short sleep done");
      do_reset(3'h4, 12'h005, 16'h0000, 8'h00, 16'h0014, 1'b1);
      len = exp_len(12'h005, 16'h0000, 8'h00);
      wait_for(0, len * T + 2 * T);
      chk_rng(n, len * T - T, len * T + T + 4, "clamped period");
      chk_bit(awake, 1'b1, "multiplier zero as one");
      // Period above range is cut to the upper limit
      do_reset(3'h4, 12'hfff, 16'h0001, 8'h00, 16'h0014, 1'b1);
      len = exp_len(12'hfff, 16'h0001, 8'h00);
      wait_for(0, len * T + 2 * T);
      chk_rng(n, len * T - T, len * T + T + 4, "clamped long period");
      $display("test clamp done");
      pend <= 1'b1;
      do_reset(3'h4, 12'h020, 16'h0001, 8'h00, 16'h000f, 1'b1);
      wait_for(0, 40 * T);
      wait_for(0, 12 * T);
      chk_rng(n, 9 * T - 1, 11 * T + 2, "awake poll interval");
      chk_bit(awake, 1'b1, "pending keeps awake");
      for (i = 0; i < 10; i++) begin
         @(posedge sys_clk) pend <= 1'b0;
         repeat ({$random(seed)} % 8 + 1) @(posedge sys_clk);
         @(posedge sys_clk) serial <= 1'b1;
         @(posedge sys_clk) serial <= 1'b0;
      end
      #1 chk_bit(awake, 1'b1, "serial restarts hold");
      wait_for(1, 20 * T);
      chk_rng(n, 14 * T, 17 * T + 2, "hold expiry");
      $display("test hold done");
      // pin wake per mode, command sleep, other modes
      do_reset(3'h4, 12'h020, 16'h0001, 8'h00, 16'h0014, 1'b1);
      wait_for(3, 10);
      @(posedge sys_clk) pin <= 1'b0;
      wait_for(3, 30);
      chk_rng(c, 0, 0, "pin ignored in mode 4");
      @(posedge sys_clk) pin <= 1'b1;
      pend <= 1'b1;
      do_reset(3'h5, 12'h020, 16'h0001, 8'h00, 16'h0014, 1'b1);
      wait_for(3, 10);
      @(posedge sys_clk) pin <= 1'b0;
      wait_for(0, 10);
      chk_rng(n, 2, 6, "pin wake latency");
      @(posedge sys_clk) cmd <= 1'b1;
      @(posedge sys_clk) cmd <= 1'b0;
      #1 chk_bit(awake, 1'b0, "command sleeps");
      chk_bit(cts_n, 1'b1, "cts on command sleep");
      pin  <= 1'b1;
      pend <= 1'b0;
      do_reset(3'h1, 12'h020, 16'h0001, 8'h00, 16'h0014, 1'b1);
      wait_for(3, 40 * T);
      chk_rng(c, 0, 0, "no polls outside cyclic modes");
      $display("test modes done");
      dly <= 4'h3;
      do_reset(3'h4, 12'h020, 16'h0003, 8'h00, 16'h0014, 1'b1);
      for (i = 1; i <= 4; i++) begin
         wait_for(0, 40 * T);
         chk_bit(awake, (i == 3), "indicator gating");
      end
      @(posedge sys_clk) radio <= 1'b1;
      @(posedge sys_clk) radio <= 1'b0;
      #1 chk_bit(awake, 1'b1, "radio raises indicator");
      $display("test multiplier done");
      dly <= 4'h1;
      do_reset(3'h4, 12'h020, 16'h0002, 8'h06, 16'h0014, 1'b0);
      len = exp_len(12'h020, 16'h0002, 8'h06);
      wait_for(0, len * T + 2 * T);
      chk_rng(n, len * T - T, len * T + T + 4, "extended sleep");
      chk_bit(wake_tx, 1'b1, "wake announcement");
      chk_bit(cts_n, 1'b0, "cts with flow control off");
      do_reset(3'h4, 12'h020, 16'h0001, 8'h02, 16'h0006, 1'b1);
      wait_for(0, 40 * T);
      wait_for(1, 10 * T);
      chk_rng(n, 5 * T, 7 * T + 2, "full hold time");
      $display("test extended done");
      mute <= 1'b1;
      do_reset(3'h4, 12'h020, 16'h0001, 8'h00, 16'h0014, 1'b1);
      wait_for(2, 160 * T);
      chk_rng(c, 3, 3, "polls before parent loss");
      mute <= 1'b0;
      $display("test parent loss done");
      end_of_test();
   end
endmodule : tb
`default_nettype wire
